// *** common/ttcg_params.svh ***
// Offsets, field positions, reset values and prescaler figures of the timer group
`ifndef TTCG_PARAMS_SVH
`define TTCG_PARAMS_SVH

// Byte offsets of the register words
`define TTCG_OFS_CTRL_LOW 5'h00
`define TTCG_OFS_CTRL_CORE 5'h04
`define TTCG_OFS_CTRL_HIGH 5'h08
`define TTCG_OFS_CNT_LOW 5'h0c
`define TTCG_OFS_CNT_CORE 5'h10
`define TTCG_OFS_CNT_HIGH 5'h14
`define TTCG_OFS_STATUS 5'h18

// Width and reset value of a control word; count reset value and top
`define TTCG_CTRL_WIDTH 14
`define TTCG_CTRL_RST 14'h0000
`define TTCG_CNT_RST 16'h0000
`define TTCG_CNT_MAX 16'hffff

// Prescaler: divide by 2^(base + select), select 0..7
`define TTCG_PRESC_BASE 4'h3
`define TTCG_PRESC_WIDTH 11

// Status word bit positions
`define TTCG_ST_LATCH 0
`define TTCG_ST_DOWN 1
`define TTCG_ST_GATE 4
`define TTCG_ST_DIR 7

`endif

// *** common/ttcg_pkg.sv ***
// Types shared by the timer group: modes, control word and bus request
package ttcg_pkg;

   // Operating modes of one timer
   typedef enum logic [2:0] {
      TTCG_TIMER,
      TTCG_GATED,
      TTCG_COUNTER,
      TTCG_INCR,
      TTCG_CAPTURE,
      TTCG_RELOAD,
      TTCG_CHAIN
   } ttcg_mode_e;

   // Control word of one timer, 14 bits, mode in the low bits
   typedef struct packed {
      logic [1:0] reload_src;   // 0 pin edge, 1 latch rise, 2 latch fall, 3 both
      logic [1:0] edge_sel;     // 0 rising, 1 falling, 2 both, 3 none
      logic gate_high;          // Gate level that lets the timer count
      logic ext_dir_en;         // Direction pin may invert the direction
      logic down;               // Software direction, 1 counts down
      logic run;
      logic [2:0] presc;
      ttcg_mode_e mode;
   } ttcg_ctrl_s;

   // Avalon-MM request from the master
   typedef struct packed {
      logic read;
      logic write;
      logic [4:0] address;
      logic [31:0] writedata;
   } ttcg_avs_req_s;

endpackage

// *** testbench/tb_top.sv ***
// Self-checking bench of the timer group: bus tasks, pin stimulus, checks
`timescale 1ns/10ps
`include "ttcg_params.svh"
module tb_top;
   import ttcg_pkg::*;
   localparam logic [4:0] a_cl = `TTCG_OFS_CTRL_LOW;
   localparam logic [4:0] a_cc = `TTCG_OFS_CTRL_CORE;
   localparam logic [4:0] a_ch = `TTCG_OFS_CTRL_HIGH;
   localparam logic [4:0] a_nl = `TTCG_OFS_CNT_LOW;
   localparam logic [4:0] a_nc = `TTCG_OFS_CNT_CORE;
   localparam logic [4:0] a_nh = `TTCG_OFS_CNT_HIGH;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   ttcg_avs_req_s req = '0;
   logic [31:0] rdata;
   logic wait_req;
   logic [2:0] pins;
   logic [2:0] dpins;
   logic [2:0] pulse = 3'h0;
   logic [2:0] dlvl = 3'h0;
   logic qreq = 1'b0;
   logic qback = 1'b0;
   logic tog;
   logic [31:0] q;
   logic [31:0] v;
   logic [31:0] seed = 32'h00008609;
   logic lat;
   logic dn;
   logic [15:0] chain;
   int errors = 0;
   int samples_checked = 0;
   int n;
   int k;
   int d;

   // Clock at 20 MHz
   always #25 clk_sys = !clk_sys;

   ttcg_top uut (.clk_sys(clk_sys), .rst(rst), .avs_req(req), .avs_readdata(rdata),
      .avs_waitrequest(wait_req), .timer_gate_clock_input(pins),
      .timer_direction_input(dpins), .timer_toggle_output(tog));

   ttcg_pin_model pm (.clk_sys(clk_sys), .pulse_req(pulse), .quad_req(qreq),
      .quad_back(qback), .dir_lvl(dlvl), .pin_in(pins), .pin_dir(dpins));

   // Repeatable stimulus source
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // Control word: mode, prescale, run, down, pin direction, edge, reload source
   function automatic logic [31:0] cw(logic [2:0] m, logic r, logic w, logic de, logic [1:0] ed,
         logic [1:0] rs);
      return {18'h0, rs, ed, 1'b0, de, w, r, 3'h0, m};
   endfunction

   // Counts per pin pulse for each edge choice: rise, fall, both, none
   function automatic int steps(logic [1:0] ed);
      return (ed == 2'h2) ? 2 : (ed == 2'h3) ? 0 : 1;
   endfunction

   task automatic chk(logic [31:0] seen, logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // One Avalon access; held until waitrequest is sampled low, only the watchdog ends a hang
   task automatic bus(logic rd, logic [4:0] a, logic [31:0] wd, output logic [31:0] rq);
      req <= '{read: rd, write: !rd, address: a, writedata: wd};
      do begin
         @(posedge clk_sys);
      end while (wait_req !== 1'b0);
      rq = rdata;
      req <= '0;
      @(posedge clk_sys);
   endtask

   task automatic wr(logic [4:0] a, logic [31:0] wd);
      bus(1'b0, a, wd, q);
   endtask

   task automatic rdc(logic [4:0] a, logic [31:0] exp);
      bus(1'b1, a, 32'h0, q);
      chk(q, exp);
   endtask

   task automatic pulse_pin(int i);
      pulse[i] <= 1'b1;
      repeat (2) @(posedge clk_sys);
      pulse[i] <= 1'b0;
      repeat (2) @(posedge clk_sys);
   endtask

   task automatic qstep(logic b);
      qback <= b;
      qreq <= 1'b1;
      @(posedge clk_sys);
      qreq <= 1'b0;
      repeat (3) @(posedge clk_sys);
   endtask

   // Cycles until the toggle output leaves level lv
   task automatic meas(logic lv, output int c);
      c = 0;
      while (tog === lv && c < 3000) begin
         @(posedge clk_sys);
         c++;
      end
   endtask

   task automatic close_out();
      $display("counts: %0d checked, %0d errors", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Hang guard, well past the few thousand cycles the tests need
   initial begin
      repeat (60000) @(posedge clk_sys);
      errors++;
      close_out();
   end

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      for (n = 0; n < 8; n++) rdc(5'(n * 4), 32'h0);
      v = rnd();
      wr(a_nl, v);
      rdc(a_nl, {16'h0, v[15:0]});
      $display("test reset and registers done");
      // Counter mode over every edge choice and direction source; wraps tracked
      lat = 1'b0;
      chain = 16'h0;
      wr(a_ch, cw(TTCG_CHAIN, 1, 0, 0, 0, 0));
      for (n = 0; n < 16; n++) begin
         v = n[0] ? (n[2] ^ n[3] ? 32'h1 : 32'hfffe) : rnd() & 32'h0000ffff;
         d = 32'(rnd() % 8) + 1;
         dlvl[1] <= n[3];
         wr(a_nc, v);
         wr(a_cc, cw(TTCG_COUNTER, 1, n[2], 1, n[1:0], 0));
         repeat (d) pulse_pin(1);
         repeat (4) @(posedge clk_sys);
         k = steps(n[1:0]) * d;
         dn = n[2] ^ n[3];
         lat = lat ^ (dn ? (v[15:0] < k) : (v[15:0] + k > 32'h0000ffff));
         chain = chain + 16'(dn ? (v[15:0] < k) : (v[15:0] + k > 32'h0000ffff));
         rdc(a_nc, (dn ? v - k : v + k) & 32'h0000ffff);
         bus(1'b1, `TTCG_OFS_STATUS, 32'h0, q);
         chk(q[0], lat);
         chk(q[2], dn);
         chk(tog, lat);
      end
      rdc(a_nh, chain);
      $display("test counter, direction and latch done");
      dlvl <= 3'h0;
      // Gated core, gate open while its pin is high: 64 open cycles make 8 ticks
      wr(a_nc, 32'h0);
      wr(a_cc, cw(TTCG_GATED, 1, 0, 0, 3, 0) | 32'h00000200);
      repeat (40) @(posedge clk_sys);
      rdc(a_nc, 32'h0);
      pulse[1] <= 1'b1;
      repeat (64) @(posedge clk_sys);
      pulse[1] <= 1'b0;
      repeat (40) @(posedge clk_sys);
      rdc(a_nc, 32'h8);
      $display("test gated timer done");
      wr(a_nc, 32'h00000064);
      wr(a_cc, cw(TTCG_INCR, 1, 0, 0, 0, 0));
      k = 32'(rnd() % 16) + 8;
      d = 32'(rnd() % 8);
      repeat (k) qstep(1'b0);
      repeat (d) qstep(1'b1);
      rdc(a_nc, 32'(32'h00000064 + k - d));
      $display("test quadrature done");
      // Capture into low aux on its pin, then reload core from high aux pin
      v = rnd() & 32'h0000ffff;
      wr(a_cc, 32'h0);
      wr(a_nc, v);
      wr(a_cl, cw(TTCG_CAPTURE, 1, 0, 0, 0, 0));
      pulse_pin(0);
      repeat (4) @(posedge clk_sys);
      rdc(a_nl, v);
      repeat (30) @(posedge clk_sys);
      rdc(a_nl, v);
      v = rnd() & 32'h0000ffff;
      wr(a_nh, v);
      wr(a_ch, cw(TTCG_RELOAD, 1, 0, 0, 0, 0));
      pulse_pin(2);
      repeat (4) @(posedge clk_sys);
      rdc(a_nc, v);
      $display("test capture and reload done");
      // PWM: rise reloads 0xfff0, fall reloads 0xffe0, prescale 8 per tick
      wr(a_cl, cw(TTCG_RELOAD, 0, 0, 0, 0, 1));
      wr(a_nl, 32'h0000fff0);
      wr(a_ch, cw(TTCG_RELOAD, 0, 0, 0, 0, 2));
      wr(a_nh, 32'h0000ffe0);
      wr(a_nc, 32'h0000fffc);
      wr(a_cc, cw(TTCG_TIMER, 1, 0, 0, 0, 0));
      meas(1'b1, k);
      meas(1'b0, k);
      meas(1'b1, k);
      chk(k, 128);
      meas(1'b0, k);
      chk(k, 256);
      $display("test pwm done");
      close_out();
   end
endmodule

// *** testbench/ttcg_pin_model.sv ***
// Pin model: pulse and level pass-through plus quadrature sensor steps
`timescale 1ns/10ps
module ttcg_pin_model (
   input wire logic clk_sys,
   input wire logic [2:0] pulse_req,
   input wire logic quad_req,
   input wire logic quad_back,
   input wire logic [2:0] dir_lvl,
   output logic [2:0] pin_in,
   output logic [2:0] pin_dir
);
   logic qa = 1'b0;
   logic qb = 1'b0;

   // Sensor A and B ride on the core timer's two pins
   assign pin_in = pulse_req ^ {1'b0, qa, 1'b0};
   assign pin_dir = dir_lvl ^ {1'b0, qb, 1'b0};

   // One phase moves per step, so a sample never sees A and B change together
   always @(posedge clk_sys) begin
      if (quad_req) begin
         if ((qa == qb) ^ quad_back) qa <= !qa;
         else qb <= !qb;
      end
   end
endmodule

// *** verilog/ttcg_top.sv ***
// Three 16-bit timer/counters (two auxiliary, one core) with an Avalon-MM register slave
`timescale 1ns/10ps
`include "ttcg_params.svh"

// Behaviour
// - Every timer holds a 16-bit count
// - Each timer selects its own mode
// - Timer mode counts prescaled CPU clocks
// - Counter mode counts edges on input pin
// - Gated mode counts only while gate open
// - One input pin per timer, gate or clock
// - Direction from software, optionally pin-modified
// - Quadrature mode derives count and direction
// - Core latch toggles on each wrap
// - Latch drives pin and clocks auxiliaries
// - Auxiliaries may serve as capture/reload
// - Capture or reload auxiliary stops counting
// - Capture copies core count on pin trigger
// - Reload loads core on pin or latch
// - Opposite latch reloads give free-running PWM
// - Timers chain into a longer count
module ttcg_top (
   input wire logic clk_sys,
   input wire logic rst,
   input wire ttcg_pkg::ttcg_avs_req_s avs_req,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [2:0] timer_gate_clock_input,
   input wire logic [2:0] timer_direction_input,
   output logic timer_toggle_output
);
   import ttcg_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Storage

   ttcg_ctrl_s ctrl [3];          // Index 0 low aux, 1 core, 2 high aux
   logic [15:0] cnt [3];
   logic [15:0] next_cnt [3];
   logic [2:0] in_s1, in_s2, in_s3;
   logic [2:0] dir_s1, dir_s2, dir_s3;
   logic [`TTCG_PRESC_WIDTH-1:0] presc_cnt;
   logic core_latch;
   logic core_latch_d;
   logic ack;

   wire [2:0] step;
   wire [2:0] down;
   wire [2:0] ovf;
   wire [2:0] pin_edge;
   wire [2:0] tick;
   wire [2:0] cap_trig;
   wire [2:0] rl_trig;
   wire [2:0] wr_cnt;
   wire [2:0] wr_ctrl;

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode

   wire wr_take = avs_req.write & ack;
   wire rd_take = avs_req.read & ~ack;
   wire [4:0] adr = avs_req.address;
   assign wr_ctrl[0] = wr_take & (adr == `TTCG_OFS_CTRL_LOW);
   assign wr_ctrl[1] = wr_take & (adr == `TTCG_OFS_CTRL_CORE);
   assign wr_ctrl[2] = wr_take & (adr == `TTCG_OFS_CTRL_HIGH);
   assign wr_cnt[0] = wr_take & (adr == `TTCG_OFS_CNT_LOW);
   assign wr_cnt[1] = wr_take & (adr == `TTCG_OFS_CNT_CORE);
   assign wr_cnt[2] = wr_take & (adr == `TTCG_OFS_CNT_HIGH);

   // Status shows live latch, directions and synchronised pin levels
   wire [31:0] status_word = {22'h000000, dir_s2, in_s2, down, core_latch};

   // Read mux; unmapped addresses answer zero
   wire [31:0] rd_mux =
      (adr == `TTCG_OFS_CTRL_LOW) ? {18'h00000, ctrl[0]} :
      (adr == `TTCG_OFS_CTRL_CORE) ? {18'h00000, ctrl[1]} :
      (adr == `TTCG_OFS_CTRL_HIGH) ? {18'h00000, ctrl[2]} :
      (adr == `TTCG_OFS_CNT_LOW) ? {16'h0000, cnt[0]} :
      (adr == `TTCG_OFS_CNT_CORE) ? {16'h0000, cnt[1]} :
      (adr == `TTCG_OFS_CNT_HIGH) ? {16'h0000, cnt[2]} :
      (adr == `TTCG_OFS_STATUS) ? status_word : 32'h00000000;

   // Latch edges feed chaining and reload
   wire latch_rise = core_latch & ~core_latch_d;
   wire latch_fall = ~core_latch & core_latch_d;
   wire latch_edge = latch_rise | latch_fall;

   ////////////////////////////////////////////////////////////////////////////
   // Per-timer count logic

   genvar i;
   generate
      for (i = 0; i < 3; i++) begin : g_tmr
         // Prescaler tap: all low bits of the free counter set
         wire [3:0] shamt = `TTCG_PRESC_BASE + {1'b0, ctrl[i].presc};
         wire [`TTCG_PRESC_WIDTH-1:0] mask = (11'h001 << shamt) - 11'h001;
         assign tick[i] = ((presc_cnt & mask) == mask);

         // Edge of the pin, as selected
         wire rise = in_s2[i] & ~in_s3[i];
         wire fall = ~in_s2[i] & in_s3[i];
         assign pin_edge[i] = (ctrl[i].edge_sel == 2'h0) ? rise :
                              (ctrl[i].edge_sel == 2'h1) ? fall :
                              (ctrl[i].edge_sel == 2'h2) ? (rise | fall) : 1'b0;

         // Quadrature decode; simultaneous change of both is ignored as invalid
         wire a_ch = in_s2[i] ^ in_s3[i];
         wire b_ch = dir_s2[i] ^ dir_s3[i];
         wire q_step = a_ch ^ b_ch;
         wire q_down = a_ch ? (in_s2[i] == dir_s2[i]) : (in_s2[i] != dir_s2[i]);

         // Mode decode
         wire m_tim = (ctrl[i].mode == TTCG_TIMER);
         wire m_gat = (ctrl[i].mode == TTCG_GATED);
         wire m_cnt = (ctrl[i].mode == TTCG_COUNTER);
         wire m_inc = (ctrl[i].mode == TTCG_INCR);
         wire m_chn = (ctrl[i].mode == TTCG_CHAIN) & (i != 1);
         wire gate_open = (in_s2[i] == ctrl[i].gate_high);

         // Capture and reload modes give no step at all
         assign step[i] = ctrl[i].run & ((m_tim & tick[i]) |
                          (m_gat & tick[i] & gate_open) |
                          (m_cnt & pin_edge[i]) |
                          (m_inc & q_step) |
                          (m_chn & latch_edge));

         assign down[i] = m_inc ? (q_down ^ ctrl[i].down) :
                          (ctrl[i].down ^ (ctrl[i].ext_dir_en & dir_s2[i]));
         // A software write or reload replaces the step, so it cannot wrap either
         wire loaded = wr_cnt[i] | ((i == 1) & (rl_trig[0] | rl_trig[2]));
         assign ovf[i] = step[i] & ~loaded &
                         (down[i] ? (cnt[i] == `TTCG_CNT_RST) : (cnt[i] == `TTCG_CNT_MAX));

         // Only auxiliaries take capture or reload duty
         if (i == 1) begin : g_core
            assign cap_trig[i] = 1'b0;
            assign rl_trig[i] = 1'b0;
         end else begin : g_aux
            wire [1:0] src = ctrl[i].reload_src;
            wire rl_ev = (src == 2'h0) ? pin_edge[i] : (src == 2'h1) ? latch_rise :
                         (src == 2'h2) ? latch_fall : latch_edge;
            assign cap_trig[i] = (ctrl[i].mode == TTCG_CAPTURE) & pin_edge[i];
            assign rl_trig[i] = (ctrl[i].mode == TTCG_RELOAD) & rl_ev;
         end

         // Priority: software write, reload, capture, then counting; wrap is natural
         wire [15:0] stepped = down[i] ? (cnt[i] - 16'h0001) : (cnt[i] + 16'h0001);
         assign next_cnt[i] = wr_cnt[i] ? avs_req.writedata[15:0] :
                              (i == 1 && rl_trig[0]) ? cnt[0] :
                              (i == 1 && rl_trig[2]) ? cnt[2] :
                              cap_trig[i] ? cnt[1] :
                              step[i] ? stepped : cnt[i];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; first stage feeds only the second

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         in_s1 <= 3'h0;
         in_s2 <= 3'h0;
         in_s3 <= 3'h0;
         dir_s1 <= 3'h0;
         dir_s2 <= 3'h0;
         dir_s3 <= 3'h0;
      end else begin
         in_s1 <= timer_gate_clock_input;
         in_s2 <= in_s1;
         in_s3 <= in_s2;
         dir_s1 <= timer_direction_input;
         dir_s2 <= dir_s1;
         dir_s3 <= dir_s2;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Timers, prescaler and core latch

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         for (int k = 0; k < 3; k++) begin
            ctrl[k] <= ttcg_ctrl_s'(`TTCG_CTRL_RST);
            cnt[k] <= `TTCG_CNT_RST;
         end
         presc_cnt <= '0;
         core_latch <= 1'b0;
         core_latch_d <= 1'b0;
         timer_toggle_output <= 1'b0;
      end else begin
         for (int k = 0; k < 3; k++) begin
            if (wr_ctrl[k]) begin
               ctrl[k] <= ttcg_ctrl_s'(avs_req.writedata[`TTCG_CTRL_WIDTH-1:0]);
            end
            cnt[k] <= next_cnt[k];
         end
         presc_cnt <= presc_cnt + 11'h001;
         core_latch <= core_latch ^ ovf[1];
         core_latch_d <= core_latch;
         timer_toggle_output <= core_latch ^ ovf[1];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Avalon slave: one wait cycle, answer registered
   // No new request is seen while ack is high, so each access costs two cycles

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ack <= 1'b0;
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h00000000;
      end else begin
         ack <= (avs_req.read | avs_req.write) & ~ack;
         avs_waitrequest <= ~((avs_req.read | avs_req.write) & ~ack);
         if (rd_take) begin
            avs_readdata <= rd_mux;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   // Core count free of writes and reloads this cycle
   wire core_free = ~wr_cnt[1] & ~rl_trig[0] & ~rl_trig[2];

   // Counting down through zero must land on all ones and flip the latch
   sequence s_core_bottom_down;
      step[1] && down[1] && cnt[1] == 16'h0000 && core_free;
   endsequence
   property p_wrap_down;
      s_core_bottom_down |=> (cnt[1] == 16'hffff) && (core_latch != $past(core_latch));
   endproperty
   a_wrap_down: assert property (p_wrap_down) else $error("core underflow or latch toggle missed");

   // A plain up step adds exactly one below the top
   property p_count_up;
      step[1] && !down[1] && cnt[1] != 16'hffff && core_free
         |=> cnt[1] == $past(cnt[1]) + 16'h0001;
   endproperty
   a_count_up: assert property (p_count_up) else $error("up count step wrong");

   sequence s_core_top_up;
      ctrl[1].mode == TTCG_TIMER && step[1] && !down[1] && cnt[1] == 16'hffff
         && !wr_cnt[1] && !rl_trig[0] && !rl_trig[2];
   endsequence
   property p_wrap_up;
      s_core_top_up |=> (cnt[1] == 16'h0000) && (core_latch != $past(core_latch));
   endproperty
   a_wrap_up: assert property (p_wrap_up) else $error("core wrap or latch toggle missed");

   property p_latch_cause;
      (core_latch != $past(core_latch)) |-> $past(ovf[1]);
   endproperty
   a_latch_cause: assert property (p_latch_cause) else $error("latch toggled without wrap");

   property p_pin_follows;
      ovf[1] |=> timer_toggle_output != $past(timer_toggle_output) && timer_toggle_output == core_latch;
   endproperty
   a_pin_follows: assert property (p_pin_follows) else $error("toggle pin differs from latch");

   property p_aux_stopped;
      (ctrl[0].mode == TTCG_RELOAD || ctrl[0].mode == TTCG_CAPTURE) && !wr_cnt[0] && !cap_trig[0]
         |=> cnt[0] == $past(cnt[0]);
   endproperty
   a_aux_stopped: assert property (p_aux_stopped) else $error("duty auxiliary kept counting");

   property p_capture;
      cap_trig[0] && !wr_cnt[0] |=> cnt[0] == $past(cnt[1]);
   endproperty
   a_capture: assert property (p_capture) else $error("capture missed core value");

   property p_reload;
      rl_trig[0] && !wr_cnt[1] |=> cnt[1] == $past(cnt[0]);
   endproperty
   a_reload: assert property (p_reload) else $error("core not reloaded");

   property p_gate_closed;
      ctrl[1].mode == TTCG_GATED && in_s2[1] != ctrl[1].gate_high && !wr_cnt[1] && !rl_trig[0] && !rl_trig[2]
         |=> $stable(cnt[1]);
   endproperty
   a_gate_closed: assert property (p_gate_closed) else $error("count moved with gate closed");

   property p_count_down;
      step[1] && down[1] && cnt[1] != 16'h0000 && core_free
         |=> cnt[1] == $past(cnt[1]) - 16'h0001;
   endproperty
   a_count_down: assert property (p_count_down) else $error("down count step wrong");

   property p_chain;
      ctrl[2].mode == TTCG_CHAIN && ctrl[2].run && latch_edge && !ctrl[2].down && !wr_cnt[2]
         |=> cnt[2] == $past(cnt[2]) + 16'h0001;
   endproperty
   a_chain: assert property (p_chain) else $error("chained timer missed latch edge");

   sequence s_req;
      (avs_req.read || avs_req.write) && !ack;
   endsequence
   property p_bus_ack;
      s_req |=> !avs_waitrequest ##1 avs_waitrequest;
   endproperty
   a_bus_ack: assert property (p_bus_ack) else $error("bus answer not in one cycle");

   // Software write to the core count wins over every other source
   sequence s_cnt_write;
      avs_req.write && ack && avs_req.address == `TTCG_OFS_CNT_CORE;
   endsequence
   property p_cnt_write;
      s_cnt_write |=> cnt[1] == $past(avs_req.writedata[15:0]);
   endproperty
   a_cnt_write: assert property (p_cnt_write) else $error("core count write lost");

   // Reload from the high auxiliary when the low one is quiet
   property p_reload_high;
      rl_trig[2] && !rl_trig[0] && !wr_cnt[1] |=> cnt[1] == $past(cnt[2]);
   endproperty
   a_reload_high: assert property (p_reload_high) else $error("core not reloaded from high auxiliary");

   // A stopped core timer holds its value while free of writes and reloads
   property p_core_stopped;
      ctrl[1].mode == TTCG_TIMER && !ctrl[1].run && core_free |=> $stable(cnt[1]);
   endproperty
   a_core_stopped: assert property (p_core_stopped) else $error("stopped core timer moved");

   // Counter mode with no edge selected ignores its pin
   property p_no_edge;
      ctrl[1].mode == TTCG_COUNTER && ctrl[1].edge_sel == 2'h3 && core_free |=> $stable(cnt[1]);
   endproperty
   a_no_edge: assert property (p_no_edge) else $error("count moved with no edge selected");

   // A read of the core count answers one cycle later with the sampled value
   sequence s_cnt_read;
      avs_req.read && !ack && avs_req.address == `TTCG_OFS_CNT_CORE;
   endsequence
   property p_cnt_read;
      s_cnt_read |=> !avs_waitrequest && avs_readdata == {16'h0000, $past(cnt[1])};
   endproperty
   a_cnt_read: assert property (p_cnt_read) else $error("core count read wrong");

endmodule
